// [core/sre_pkg.sv]
// constants, state codes and timing for the bus slave with ram and eeprom
// assumes a single 250 MHz clock and synchronous active-low reset
// Operation
// R1: address is 10101 plus two select pins
// R2: identification and brand registers readable, read only
// R3: sda falling while scl high opens transfer
// R4: eight bits msb first, last bit direction
// R5: acknowledge own address, stay idle otherwise
// R6: nine clocks per byte, sda rise is stop
// R7: first written byte is the command
// R8: master ends read with nack then stop
// R9: ram 0x00-0xdf, eeprom 0xf800-0xf9ff, bytewise
// R10: program only erased bytes, erase whole pages
// R11: erase only when control bit 3 set
// R12: send byte with ram address loads pointer
// R13: command 0xfe erases selected page at once
// R14: no acknowledge while page erase runs
// R15: write byte to ram stores data
// R16: command 0xf8/0xf9 plus byte sets pointer
// R17: erase page from pointer, low five bits ignored
// R18: write word programs one eeprom byte
// R19: block write: 0xfc, count, data bytes
// R20: master keeps block inside erased eeprom
// R21: hold scl low while eeprom programs; the code holds it only at the start of a written data byte
// R22: receive byte returns byte at pointer
// R23: block read returns 0x20 then 32 bytes
// R24: no acknowledge before configuration loaded
// R25: block transfers advance pointer per byte
package sre_pkg;
  localparam int CLK_MHZ = 250;
  localparam int ERASE_TIME_US = 20000;
  localparam int PROG_TIME_US = 250;
  localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
  localparam int EE_DEPTH = 512;
  localparam int EE_PAGE = 32;
  localparam int RAM_DEPTH = 224;
  localparam logic [4:0] SLV_ADDR_HI = 5'h15;
  localparam logic [7:0] RAM_TOP = 8'hdf;
  localparam logic [15:0] EE_BASE = 16'hf800;
  localparam logic [15:0] EE_TOP = 16'hf9ff;
  localparam logic [7:0] EE_HI_LO = 8'hf8;
  localparam logic [7:0] EE_HI_HI = 8'hf9;
  localparam logic [7:0] CMD_BLK_WR = 8'hfc;
  localparam logic [7:0] CMD_BLK_RD = 8'hfd;
  localparam logic [7:0] CMD_ERASE = 8'hfe;
  localparam logic [7:0] BLK_BYTES = 8'h20;
  localparam logic [7:0] REG_CFG_UPD = 8'h90;
  localparam logic [7:0] REG_MANUF = 8'h93;
  localparam logic [7:0] REG_DEVICE = 8'h94;
  localparam logic [7:0] REG_REV = 8'h95;
  localparam logic [7:0] REG_BRAND1 = 8'h96;
  localparam logic [7:0] REG_BRAND2 = 8'h97;
  localparam int CFG_ERASE_BIT = 3;
  localparam logic [7:0] CFG_RW_MASK = 8'h09;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] EE_ERASED = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WRB = 3'b011,
    ST_WACK = 3'b100,
    ST_RDB = 3'b101,
    ST_RACK = 3'b110,
    ST_WAIT = 3'b111
  } sre_state_t;
endpackage : sre_pkg

// [core/sre_sync.sv]
// two-flop synchroniser for pins from outside the clock domain
// assumes inputs are slow compared with clk
`timescale 1ns/1ps
module sre_sync import sre_pkg::*; #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RST = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!rstn) begin
        meta_q[i] <= RST[i];
        sync_q[i] <= RST[i];
      end else begin
        meta_q[i] <= async_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end
  assign sync_out = sync_q;
endmodule : sre_sync

// [core/sre_nvm.sv]
// eeprom array with page erase and byte program busy timing
// assumes strobes come only while both busy flags are low
`timescale 1ns/1ps
module sre_nvm import sre_pkg::*; #(
  parameter int DEPTH = EE_DEPTH,
  parameter int PAGE = EE_PAGE,
  parameter int AW = $clog2(DEPTH),
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // access
  input wire logic prog,
  input wire logic erase,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // status
  output logic prog_busy,
  output logic erase_busy
);
  localparam int CW = $clog2(ERASE_CYCLES + PROG_CYCLES + 1);
  localparam int PW = $clog2(PAGE);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic pbusy;
    logic ebusy;
  } sre_nvm_t;
  sre_nvm_t s;
  sre_nvm_t n;
  logic [7:0] mem [DEPTH];
  logic idle;
  logic blank;
  assign idle = !s.pbusy && !s.ebusy;
  assign blank = (mem[addr] == EE_ERASED);
  assign rdata = mem[addr];
  assign prog_busy = s.pbusy;
  assign erase_busy = s.ebusy;
  always_comb begin
    n = s;
    if (!idle) begin
      n.cnt = s.cnt - CW'(1);
      if (s.cnt <= CW'(1)) begin
        n.pbusy = 1'b0;
        n.ebusy = 1'b0;
      end
    end else if (erase) begin
      n.ebusy = 1'b1;
      n.cnt = CW'(ERASE_CYCLES);
    end else if (prog && blank) begin
      n.pbusy = 1'b1; // R10
      n.cnt = CW'(PROG_CYCLES);
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
  // content persists through reset, as a real array would
  always_ff @(posedge clk) begin
    if (idle && erase) begin
      for (int i = 0; i < PAGE; i++) begin
        mem[{addr[AW-1:PW], PW'(i)}] <= EE_ERASED; // R10 R17
      end
    end else if (idle && prog && blank) begin
      mem[addr] <= wdata; // R10
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  erase_start_a: assert property (idle && erase |=> erase_busy && !prog_busy) // R14
    else $error("erase did not raise busy");
  busy_excl_a: assert property (!(prog_busy && erase_busy)) // R10
    else $error("program and erase busy together");
  prog_skip_a: assert property (idle && prog && !erase && !blank |=> !prog_busy) // R10
    else $error("programmed a byte that was not erased");
endmodule : sre_nvm

// [core/sre_slave.sv]
// two-wire bus slave giving access to register ram and eeprom
// assumes open-drain scl and sda resolved outside, pins asynchronous
`timescale 1ns/1ps
module sre_slave import sre_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int ERASE_CYCLES = ERASE_CYC,
  // identification values, arbitrary
  parameter logic [7:0] MANUF_ID = 8'h5a,
  parameter logic [7:0] DEVICE_ID = 8'h01,
  parameter logic [7:0] REV_ID = 8'h01,
  parameter logic [7:0] BRAND1_ID = 8'h00,
  parameter logic [7:0] BRAND2_ID = 8'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // address select pins
  input wire logic addr_select_high_pin,
  input wire logic addr_select_low_pin,
  // configuration download finished
  input wire logic cfg_loaded,
  // serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  typedef struct packed {
    sre_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] cmd;
    logic [15:0] ptr;
    logic [7:0] bcnt;
    logic [5:0] bi;
    logic [5:0] rbi;
    logic [7:0] cfg;
    logic rd;
    logic blk_rd;
    logic mack;
    logic scl_p;
    logic sda_p;
    logic scl_oe_n;
    logic sda_oe_n;
  } sre_regs_t;

  sre_regs_t s;
  sre_regs_t n;
  logic [7:0] ram_q [RAM_DEPTH];
  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic a_hi_s;
  logic a_lo_s;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic match;
  logic ram_hit;
  logic ee_hit;
  logic addr_done;
  logic [7:0] rd_byte;
  logic [7:0] ee_rdata;
  logic ee_pbusy;
  logic ee_ebusy;
  logic ee_prog;
  logic ee_erase;
  logic ram_we;
  logic wr_go;
  logic load;
  logic [7:0] ld_byte;

  // pins pass two flops before anything looks at them
  sre_sync #(
    .WIDTH(4),
    .RST(4'hf)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({scl_i, sda_i, addr_select_high_pin, addr_select_low_pin}),
    .sync_out(pins_s)
  );
  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign a_hi_s = pins_s[1];
  assign a_lo_s = pins_s[0];

  sre_nvm #(
    .DEPTH(EE_DEPTH),
    .PAGE(EE_PAGE),
    .AW(9),
    .PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
  ) u_nvm (
    .clk(clk),
    .rstn(rstn),
    .prog(ee_prog),
    .erase(ee_erase),
    .addr(s.ptr[8:0]),
    .wdata(s.sh),
    .rdata(ee_rdata),
    .prog_busy(ee_pbusy),
    .erase_busy(ee_ebusy)
  );

  assign scl_rise = scl_s && !s.scl_p;
  assign scl_fall = !scl_s && s.scl_p;
  assign start = scl_s && s.scl_p && s.sda_p && !sda_s; // R3
  assign stop = scl_s && s.scl_p && !s.sda_p && sda_s; // R6
  assign match = (s.sh[7:1] == {SLV_ADDR_HI, a_hi_s, a_lo_s}); // R1
  assign ram_hit = (s.ptr[15:8] == 8'h00) && (s.ptr[7:0] <= RAM_TOP); // R9
  assign ee_hit = (s.ptr >= EE_BASE) && (s.ptr <= EE_TOP); // R9
  assign addr_done = (s.st == ST_ADDR) && scl_fall && (s.cnt == 4'h8);

  // byte seen at the pointer, identification overrides ram
  always_comb begin
    rd_byte = 8'h00;
    if (ram_hit) begin
      if (s.ptr[7:0] == REG_CFG_UPD) begin
        rd_byte = s.cfg;
      end else if (s.ptr[7:0] == REG_MANUF) begin
        rd_byte = MANUF_ID; // R2
      end else if (s.ptr[7:0] == REG_DEVICE) begin
        rd_byte = DEVICE_ID; // R2
      end else if (s.ptr[7:0] == REG_REV) begin
        rd_byte = REV_ID; // R2
      end else if (s.ptr[7:0] == REG_BRAND1) begin
        rd_byte = BRAND1_ID; // R2
      end else if (s.ptr[7:0] == REG_BRAND2) begin
        rd_byte = BRAND2_ID; // R2
      end else begin
        rd_byte = ram_q[s.ptr[7:0]]; // R22
      end
    end else if (ee_hit) begin
      rd_byte = ee_rdata; // R22
    end
  end

  always_comb begin
    n = s;
    ee_prog = 1'b0;
    ee_erase = 1'b0;
    ram_we = 1'b0;
    wr_go = 1'b0;
    load = 1'b0;
    ld_byte = rd_byte;
    n.scl_p = scl_s;
    n.sda_p = sda_s;
    if (start) begin
      n.st = ST_ADDR; // R3
      n.cnt = 4'h0;
      n.bi = 6'h00;
      n.rbi = 6'h00;
      n.sda_oe_n = 1'b1;
    end else if (stop) begin
      n.st = ST_IDLE; // R6
      n.sda_oe_n = 1'b1;
    end else begin
      case (s.st)
        ST_ADDR, ST_WRB: begin
          if (scl_rise && s.cnt < 4'h8) begin
            n.sh = {s.sh[6:0], sda_s}; // R4
            n.cnt = s.cnt + 4'h1;
          end else if (scl_fall && s.cnt == 4'h8) begin
            if (s.st == ST_ADDR) begin
              // busy erase or unloaded config: stay silent
              if (match && !ee_ebusy && cfg_loaded) begin
                n.sda_oe_n = 1'b0; // R5 R14 R24
                n.rd = s.sh[0]; // R4
                n.st = ST_AACK;
              end else begin
                n.st = ST_WAIT; // R5
              end
            end else begin
              n.sda_oe_n = 1'b0; // R19
              n.st = ST_WACK;
              if (s.bi != 6'h3f) begin
                n.bi = s.bi + 6'h01;
              end
              if (s.bi == 6'h00) begin
                n.cmd = s.sh; // R7
                n.blk_rd = (s.sh == CMD_BLK_RD); // R23
                if (s.sh <= RAM_TOP) begin
                  n.ptr = {8'h00, s.sh}; // R12
                end
                if (s.sh == CMD_ERASE && s.cfg[CFG_ERASE_BIT] && ee_hit) begin
                  ee_erase = 1'b1; // R11 R13 R17
                end
              end else if (s.cmd <= RAM_TOP) begin
                if (s.bi == 6'h01) begin
                  wr_go = 1'b1; // R15
                end
              end else if (s.cmd == EE_HI_LO || s.cmd == EE_HI_HI) begin
                if (s.bi == 6'h01) begin
                  n.ptr = {s.cmd, s.sh}; // R16
                end else if (s.bi == 6'h02) begin
                  wr_go = 1'b1; // R18
                end
              end else if (s.cmd == CMD_BLK_WR) begin
                if (s.bi == 6'h01) begin
                  n.bcnt = (s.sh > BLK_BYTES) ? BLK_BYTES : s.sh; // R19
                end else if (s.bcnt != 8'h00) begin
                  wr_go = 1'b1; // R19
                  n.ptr = s.ptr + 16'h0001; // R25
                  n.bcnt = s.bcnt - 8'h01;
                end
              end
            end
          end
        end
        ST_AACK, ST_WACK: begin
          if (scl_fall) begin
            n.sda_oe_n = 1'b1; // R6
            n.cnt = 4'h0;
            n.st = ST_WRB;
            if (s.st == ST_AACK && s.rd) begin
              load = 1'b1;
            end
          end
        end
        ST_RDB: begin
          if (scl_fall) begin
            if (s.cnt < 4'h8) begin
              n.sda_oe_n = s.tx[7]; // R6
              n.tx = {s.tx[6:0], 1'b0};
              n.cnt = s.cnt + 4'h1;
            end else begin
              n.sda_oe_n = 1'b1;
              n.st = ST_RACK;
              n.mack = 1'b0;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            n.mack = !sda_s;
            if (sda_s) begin
              n.st = ST_WAIT; // R8
            end
          end else if (scl_fall && s.mack) begin
            load = 1'b1;
          end
        end
        ST_IDLE, ST_WAIT: begin
          n.sda_oe_n = 1'b1;
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
    // next byte to send: count first on a block read
    if (load) begin
      if (s.blk_rd && s.rbi == 6'h00) begin
        ld_byte = BLK_BYTES; // R23
      end else if (s.blk_rd) begin
        n.ptr = s.ptr + 16'h0001; // R25
      end
      if (s.rbi != 6'h3f) begin
        n.rbi = s.rbi + 6'h01;
      end
      n.sda_oe_n = ld_byte[7];
      n.tx = {ld_byte[6:0], 1'b0};
      n.cnt = 4'h1;
      n.st = ST_RDB;
    end
    // writes land on the pointer before any update of it
    if (wr_go) begin
      if (ram_hit) begin
        ram_we = 1'b1; // R15
        if (s.ptr[7:0] == REG_CFG_UPD) begin
          n.cfg = s.sh & CFG_RW_MASK;
        end
      end else if (ee_hit) begin
        ee_prog = 1'b1; // R18 R19
      end
    end
    // stretch only before the next data byte, never mid-byte
    n.scl_oe_n = !(n.st == ST_WRB && n.cnt == 4'h0 && (ee_pbusy || ee_prog)); // R21
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.cfg <= CFG_RESET;
      s.scl_p <= 1'b1;
      s.sda_p <= 1'b1;
      s.scl_oe_n <= 1'b1;
      s.sda_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ram is storage only, left unreset
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_q[s.ptr[7:0]] <= s.sh; // R15
    end
  end

  // open drain: output level is always low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = s.scl_oe_n;
  assign sda_oe_n = s.sda_oe_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence ack_slot_s;
    (s.st == ST_WACK) ##0 scl_fall;
  endsequence
  sequence blk_first_s;
    load ##0 (s.blk_rd && s.rbi == 6'h00);
  endsequence

  addr_ack_a: assert property ( // R5
    addr_done && match && !ee_ebusy && cfg_loaded |=> !sda_oe_n && s.st == ST_AACK)
    else $error("own address not acknowledged");
  addr_nack_a: assert property ( // R5
    addr_done && !match |=> sda_oe_n && s.st == ST_WAIT)
    else $error("foreign address acknowledged");
  erase_nack_a: assert property (addr_done && ee_ebusy |=> sda_oe_n [*2]) // R14
    else $error("acknowledged during erase");
  load_nack_a: assert property (addr_done && !cfg_loaded |=> sda_oe_n) // R24
    else $error("acknowledged before configuration loaded");
  start_seen_a: assert property (start |=> s.st == ST_ADDR && s.cnt == 4'h0) // R3
    else $error("start not detected");
  stop_seen_a: assert property (stop |=> s.st == ST_IDLE && sda_oe_n) // R6
    else $error("stop not detected");
  erase_gate_a: assert property ( // R11
    ee_erase |-> s.cfg[CFG_ERASE_BIT] && s.sh == CMD_ERASE && s.bi == 6'h00)
    else $error("erase without enable");
  ack_release_a: assert property (ack_slot_s |=> sda_oe_n || s.st == ST_RDB) // R6
    else $error("sda held past acknowledge");
  stretch_hold_a: assert property ( // R21
    s.st == ST_WRB && s.cnt == 4'h0 && ee_pbusy && !start && !stop |=> !scl_oe_n)
    else $error("scl not stretched while programming");
  blk_count_a: assert property (blk_first_s |=> s.tx == {BLK_BYTES[6:0], 1'b0}) // R23
    else $error("block read count byte wrong");
endmodule : sre_slave

// [verification/sre_bus_master.sv]
// two-wire bus master model, pulls scl and sda low as open drain
// assumes the bench resolves both wires with pull-ups; moves on falling clk edges
`timescale 1ns/1ps
module sre_bus_master (
  // clock
  input wire logic clk,
  // resolved wires
  input wire logic scl,
  input wire logic sda,
  // master pulls, 0 = pull low
  output logic scl_m,
  output logic sda_m
);
  int stretch_max;
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    stretch_max = 0;
  end
  // quarter of a 128 ns bit period
  task automatic q();
    repeat (8) @(negedge clk);
  endtask : q
  // release scl, then wait out any stretch under a bound
  task automatic rise();
    int n;
    n = 0;
    scl_m = 1'b1;
    @(negedge clk);
    while (scl !== 1'b1 && n < 4000) begin
      n++;
      @(negedge clk);
    end
    if (n > stretch_max) stretch_max = n;
    if (n >= 4000) begin
      tb_top.n_errors++;
      tb_top.end_sim();
    end
  endtask : rise
  // also serves as repeated start when scl is low
  task automatic start();
    q();
    sda_m = 1'b1;
    q();
    rise();
    q();
    sda_m = 1'b0;
    q();
    scl_m = 1'b0;
  endtask : start
  task automatic stop();
    q();
    sda_m = 1'b0;
    q();
    rise();
    q();
    sda_m = 1'b1;
    repeat (3) q();
  endtask : stop
  // data moves only while scl is low
  task automatic wbit(input logic b);
    q();
    sda_m = b;
    q();
    rise();
    repeat (2) q();
    scl_m = 1'b0;
  endtask : wbit
  task automatic rbit(output logic b);
    q();
    sda_m = 1'b1;
    q();
    rise();
    q();
    b = sda;
    q();
    scl_m = 1'b0;
  endtask : rbit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(b);
    ack = ~b;
  endtask : wbyte
  // last byte of a read is answered with a released line
  task automatic rbyte(input logic nak, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(nak);
  endtask : rbyte
endmodule : sre_bus_master

// [verification/tb_top.sv]
// self-checking bench for the bus slave: register, ram and eeprom traffic
// assumes the design checks itself with inline assertions; short nvm timings
`timescale 1ns/1ps
module tb_top;
  import sre_pkg::*;
  typedef logic [7:0] sre_bytes_t[$];
  // identification values, arbitrary
  localparam logic [7:0] T_ID[5] = '{8'h6c, 8'h12, 8'h03, 8'h21, 8'h42};
  localparam int T_ERASE = 600;
  logic clk, rstn, a_hi, a_lo, cfg_loaded, ack, scl_m, sda_m;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_w, sda_w;
  logic [7:0] d;
  logic [7:0] exp_blk[32];
  int n_errors, checks_done;
  // wired-and with pull-ups
  assign scl_w = scl_m & scl_oe_n;
  assign sda_w = sda_m & sda_oe_n;
  // program time outlasts an ack bit, else the stretch never shows on the wire
  sre_slave #(.PROG_CYCLES(100), .ERASE_CYCLES(T_ERASE), .MANUF_ID(T_ID[0]),
    .DEVICE_ID(T_ID[1]), .REV_ID(T_ID[2]), .BRAND1_ID(T_ID[3]), .BRAND2_ID(T_ID[4])) u_dut (
    .clk(clk), .rstn(rstn), .addr_select_high_pin(a_hi), .addr_select_low_pin(a_lo),
    .cfg_loaded(cfg_loaded), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  sre_bus_master u_mst (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_m(scl_m), .sda_m(sda_m));
  always #2 clk = ~clk;
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp8(input string name, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask : cmp8
  task automatic addr(input logic rd, input logic e);
    u_mst.start();
    u_mst.wbyte({SLV_ADDR_HI, a_hi, a_lo, rd}, ack);
    cmp8("address ack", {7'h00, e}, {7'h00, ack});
  endtask : addr
  // whole write transfer, every byte expected to be acknowledged
  task automatic wr(input sre_bytes_t b, input logic stop_it = 1'b1);
    addr(1'b0, 1'b1);
    foreach (b[i]) begin
      u_mst.wbyte(b[i], ack);
      cmp8("byte ack", 8'h01, {7'h00, ack});
    end
    if (stop_it) u_mst.stop();
  endtask : wr
  task automatic rd1(input string name, input logic [7:0] e);
    addr(1'b1, 1'b1);
    u_mst.rbyte(1'b1, d);
    u_mst.stop();
    cmp8(name, e, d);
  endtask : rd1
  task automatic nak_probe();
    addr(1'b0, 1'b0);
    u_mst.stop();
  endtask : nak_probe
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    a_hi = 1'b1;
    a_lo = 1'b0;
    cfg_loaded = 1'b0;
    n_errors = 0;
    checks_done = 0;
    // three edges for the pin synchronisers
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    nak_probe();
    cfg_loaded = 1'b1;
    a_hi = 1'b0;
    repeat (4) @(negedge clk);
    u_mst.start();
    u_mst.wbyte(8'hac, ack);
    cmp8("foreign ack", 8'h00, {7'h00, ack});
    u_mst.stop();
    a_lo = 1'b1;
    repeat (4) @(negedge clk);
    wr('{8'h10, 8'h55});
    wr('{RAM_TOP, 8'ha6});
    wr('{8'h10});
    rd1("ram 10", 8'h55);
    rd1("ram 10 again", 8'h55);
    wr('{RAM_TOP});
    rd1("ram df", 8'ha6);
    for (int i = 0; i < 5; i++) begin
      wr('{REG_MANUF + 8'(i), 8'hff});
      wr('{REG_MANUF + 8'(i)});
      rd1("id register", T_ID[i]);
    end
    // erase page nine through a pointer with low bits set
    wr('{REG_CFG_UPD, 8'h08});
    wr('{8'hf9, 8'h3f});
    wr('{CMD_ERASE});
    nak_probe();
    repeat (T_ERASE) @(negedge clk);
    wr('{8'hf9, 8'h20});
    rd1("erased", EE_ERASED);
    wr('{8'hf9, 8'h20, 8'h3c});
    rd1("programmed", 8'h3c);
    wr('{8'hf9, 8'h20, 8'hff});
    rd1("no overprogram", 8'h3c);
    wr('{REG_CFG_UPD, 8'h00});
    wr('{8'hf9, 8'h20});
    wr('{CMD_ERASE});
    addr(1'b1, 1'b1);
    u_mst.rbyte(1'b1, d);
    u_mst.stop();
    cmp8("erase refused", 8'h3c, d);
    // block write across the stretch, then read the page back
    u_mst.stretch_max = 0;
    wr('{8'hf9, 8'h21});
    wr('{CMD_BLK_WR, 8'h03, 8'ha1, 8'hb2, 8'hc3});
    cmp8("stretch seen", 8'h01, {7'h00, u_mst.stretch_max > 0});
    foreach (exp_blk[i]) exp_blk[i] = EE_ERASED;
    exp_blk[0] = 8'h3c;
    exp_blk[1] = 8'ha1;
    exp_blk[2] = 8'hb2;
    exp_blk[3] = 8'hc3;
    wr('{8'hf9, 8'h20});
    wr('{CMD_BLK_RD}, 1'b0);
    addr(1'b1, 1'b1);
    u_mst.rbyte(1'b0, d);
    cmp8("block count", BLK_BYTES, d);
    for (int i = 0; i < 32; i++) begin
      u_mst.rbyte(i == 31, d);
      cmp8("block data", exp_blk[i], d);
    end
    u_mst.stop();
    // block write to ram and a single read of its second byte after it
    wr('{8'h20});
    wr('{CMD_BLK_WR, 8'h02, 8'h5e, 8'h6f});
    wr('{8'h21});
    rd1("ram block", 8'h6f);
    // open-drain pins only ever pull low
    cmp8("open drain levels", 8'h00, {6'h00, scl_o, sda_o});
    end_sim();
  end
endmodule : tb_top
